/* File: core/pdto_deadband.sv */
// Edge delay stage for one output leg
`timescale 1ns/1ps
`default_nettype none
module pdto_deadband (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // Control
    input  wire logic        sig_in,
    input  wire logic [13:0] delay_in,
    input  wire logic        delay_fall_in,
    // Result
    output logic             sig_out
);
    logic        out_q;
    logic [13:0] cnt_q;
    logic        delayed_edge;

    assign delayed_edge = delay_fall_in ? (out_q & ~sig_in) : (~out_q & sig_in);
    assign sig_out      = out_q;

    // =====================================================
    // Edge delay
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            out_q <= 1'b0;
            cnt_q <= 14'h0000;
        end else if (sig_in != out_q) begin
            if (!delayed_edge || cnt_q >= delay_in) begin
                out_q <= sig_in;
                cnt_q <= 14'h0000;
            end else begin
                cnt_q <= cnt_q + 14'h0001;
            end
        end else begin
            cnt_q <= 14'h0000;
        end
    end

endmodule : pdto_deadband
`default_nettype wire

/* File: core/pdto_top.sv */
// Dead-time, trigger divider and pin control slice with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pdto_map.svh"
module pdto_top #(
    parameter logic PRIMARY_GEN = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Generator and time base
    input  wire logic        pwm_module_enable_in,
    input  wire logic        period_end_in,
    input  wire logic        trig_event_in,
    input  wire logic        gen_high_in,
    // Protection and lock
    input  wire logic        fault_active_in,
    input  wire logic        limit_active_in,
    input  wire logic        current_limit_mode_in,
    input  wire logic        write_lock_config_in,
    input  wire logic        unlock_seq_in,
    // Pins, triggers and active dead-time values
    output logic             high_output_out,
    output logic             low_output_out,
    output logic             high_pin_owner_out,
    output logic             low_pin_owner_out,
    output logic             trig_out,
    output logic             trig_irq_req_out,
    output logic [13:0]      dead_time_value_out,
    output logic [13:0]      alt_dead_time_value_out
);
    // =====================================================
    // Declarations
    logic [7:0]  wr_addr_q, rd_addr_q;
    logic [15:0] wr_data_q;
    logic [1:0]  wr_strb_q;
    logic        aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic        wr_fire, io_write_ok, wr_hit, rd_hit;
    logic [15:0] rd_word;
    logic [13:0] dt_shadow_q, dt_active_q, alt_shadow_q, alt_active_q;
    logic [3:0]  trigger_divider_q, div_cnt_q;
    logic [5:0]  trigger_start_delay_q, wait_cnt_q;
    logic [15:0] io_q;
    logic [1:0]  dead_time_ctrl_q;
    logic        immediate_update_q, unlocked_q;
    logic [1:0]  ov_en_eff_q, ov_dat_eff_q;
    logic        pp_phase_q, trig_q, high_q, low_q;
    pdto_pkg::pdto_trg_state_t trg_state_q;
    pdto_pkg::pdto_pair_mode_t output_pair_mode;
    logic        pair_h, pair_l, db_h, db_l, sw_h, sw_l, lvl_h, lvl_l;
    logic [13:0] delay_h, delay_l;
    logic        delay_fall;
    logic [15:0] dt_merged, alt_merged;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  strb);
        merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
                   strb[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge16

    // =====================================================
    // AXI4-Lite write channel
    assign s_axi_awready_out = !aw_held_q && !bvalid_q;
    assign s_axi_wready_out  = !w_held_q && !bvalid_q;
    assign wr_fire           = aw_held_q && w_held_q && !bvalid_q;
    assign io_write_ok       = !write_lock_config_in || unlocked_q;
    assign wr_hit            = (wr_addr_q == `PDTO_ADDR_DT) || (wr_addr_q == `PDTO_ADDR_ALT)
                               || (wr_addr_q == `PDTO_ADDR_TRG) || (wr_addr_q == `PDTO_ADDR_CTRL)
                               || (wr_addr_q == `PDTO_ADDR_STAT)
                               || ((wr_addr_q == `PDTO_ADDR_IO) && io_write_ok);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 16'h0000;
            wr_strb_q <= 2'h0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_q <= 1'b1;
                wr_addr_q <= {s_axi_awaddr_in[7:2], 2'h0};
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_q  <= 1'b1;
                wr_data_q <= s_axi_wdata_in[15:0];
                wr_strb_q <= s_axi_wstrb_in[1:0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `PDTO_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `PDTO_RESP_OKAY : `PDTO_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out  = bresp_q;

    // =====================================================
    // AXI4-Lite read channel
    assign s_axi_arready_out = !rvalid_q;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 16'h0000;
        case (s_axi_araddr_in[7:2])
            6'h00: rd_word = {2'h0, dt_shadow_q};
            6'h01: rd_word = {2'h0, alt_shadow_q};
            6'h02: rd_word = {trigger_divider_q, 6'h00, trigger_start_delay_q};
            6'h03: rd_word = io_q;
            6'h04: rd_word = {8'h00, dead_time_ctrl_q, 5'h00, immediate_update_q};
            6'h05: rd_word = {2'h0, pp_phase_q, unlocked_q, div_cnt_q, trg_state_q,
                              wait_cnt_q[4:0]};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `PDTO_RESP_OKAY;
            rd_addr_q <= 8'h00;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            rvalid_q  <= 1'b1;
            rdata_q   <= {16'h0000, rd_word};
            rresp_q   <= rd_hit ? `PDTO_RESP_OKAY : `PDTO_RESP_SLVERR;
            rd_addr_q <= {s_axi_araddr_in[7:2], 2'h0};
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out  = rdata_q;
    assign s_axi_rresp_out  = rresp_q;

    // =====================================================
    // Dead-time registers
    assign dt_merged  = merge16({2'h0, dt_shadow_q}, wr_data_q, wr_strb_q);
    assign alt_merged = merge16({2'h0, alt_shadow_q}, wr_data_q, wr_strb_q);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dt_shadow_q  <= 14'h0000;
            alt_shadow_q <= 14'h0000;
        end else if (wr_fire) begin
            if (wr_addr_q == `PDTO_ADDR_DT)
                dt_shadow_q <= dt_merged[13:0];
            if (wr_addr_q == `PDTO_ADDR_ALT)
                alt_shadow_q <= alt_merged[13:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dt_active_q  <= 14'h0000;
            alt_active_q <= 14'h0000;
        end else if (immediate_update_q || period_end_in) begin
            dt_active_q  <= dt_shadow_q;
            alt_active_q <= alt_shadow_q;
        end
    end

    assign dead_time_value_out     = dt_active_q;
    assign alt_dead_time_value_out = alt_active_q;

    // =====================================================
    // Trigger, control and pin control registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trigger_divider_q     <= 4'h0;
            trigger_start_delay_q <= 6'h00;
            dead_time_ctrl_q      <= 2'h0;
            immediate_update_q    <= 1'b0;
        end else if (wr_fire) begin
            if (wr_addr_q == `PDTO_ADDR_TRG) begin
                if (wr_strb_q[1])
                    trigger_divider_q <= wr_data_q[`PDTO_TRG_DIV_LSB +: 4];
                if (wr_strb_q[0])
                    trigger_start_delay_q <= wr_data_q[`PDTO_TRG_STRT_LSB +: 6];
            end
            if (wr_addr_q == `PDTO_ADDR_CTRL && wr_strb_q[0]) begin
                dead_time_ctrl_q   <= wr_data_q[`PDTO_CTRL_DTC_LSB +: 2];
                immediate_update_q <= wr_data_q[`PDTO_CTRL_IUE];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_q <= `PDTO_RST_IO;
        end else if (wr_fire && wr_addr_q == `PDTO_ADDR_IO && io_write_ok) begin
            io_q <= merge16(io_q, wr_data_q, wr_strb_q);
        end
    end

    // Unlock arms one write; a new unlock in the consuming cycle wins
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            unlocked_q <= 1'b0;
        end else if (unlock_seq_in) begin
            unlocked_q <= 1'b1;
        end else if (wr_fire && wr_addr_q == `PDTO_ADDR_IO) begin
            unlocked_q <= 1'b0;
        end
    end

    assign high_pin_owner_out = io_q[`PDTO_IO_OWN_H];
    assign low_pin_owner_out  = io_q[`PDTO_IO_OWN_L];

    // =====================================================
    // Trigger postscaler
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trg_state_q <= pdto_pkg::PDTO_TRG_OFF;
            wait_cnt_q  <= 6'h00;
            div_cnt_q   <= 4'h0;
            trig_q      <= 1'b0;
        end else begin
            trig_q <= 1'b0;
            case (trg_state_q)
                pdto_pkg::PDTO_TRG_OFF: begin
                    div_cnt_q  <= 4'h0;
                    wait_cnt_q <= trigger_start_delay_q;
                    if (pwm_module_enable_in)
                        trg_state_q <= (trigger_start_delay_q == 6'h00) ?
                                       pdto_pkg::PDTO_TRG_RUN : pdto_pkg::PDTO_TRG_WAIT;
                end
                pdto_pkg::PDTO_TRG_WAIT: begin
                    if (!pwm_module_enable_in) begin
                        trg_state_q <= pdto_pkg::PDTO_TRG_OFF;
                    end else if (period_end_in) begin
                        wait_cnt_q <= wait_cnt_q - 6'h01;
                        if (wait_cnt_q == 6'h01)
                            trg_state_q <= pdto_pkg::PDTO_TRG_RUN;
                    end
                end
                pdto_pkg::PDTO_TRG_RUN: begin
                    if (!pwm_module_enable_in) begin
                        trg_state_q <= pdto_pkg::PDTO_TRG_OFF;
                    end else if (trig_event_in) begin
                        if (div_cnt_q >= trigger_divider_q) begin
                            div_cnt_q <= 4'h0;
                            trig_q    <= 1'b1;
                        end else begin
                            div_cnt_q <= div_cnt_q + 4'h1;
                        end
                    end
                end
                default: trg_state_q <= pdto_pkg::PDTO_TRG_OFF;
            endcase
        end
    end

    assign trig_out         = trig_q;
    assign trig_irq_req_out = trig_q && PRIMARY_GEN;

    // =====================================================
    // Pair mode and dead time
    assign output_pair_mode = pdto_pkg::pdto_pair_mode_t'(io_q[`PDTO_IO_MODE_LSB +: 2]);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            pp_phase_q <= 1'b0;
        else if (!pwm_module_enable_in)
            pp_phase_q <= 1'b0;
        else if (period_end_in)
            pp_phase_q <= !pp_phase_q;
    end

    always_comb begin
        pair_h = gen_high_in;
        pair_l = !gen_high_in;
        case (output_pair_mode)
            pdto_pkg::PDTO_PM_REDUN: pair_l = gen_high_in;
            pdto_pkg::PDTO_PM_PUSH: begin
                pair_h = gen_high_in && !pp_phase_q;
                pair_l = gen_high_in && pp_phase_q;
            end
            default: pair_l = !gen_high_in;
        endcase
    end

    always_comb begin
        delay_h    = dt_active_q;
        delay_l    = alt_active_q;
        delay_fall = 1'b0;
        case (pdto_pkg::pdto_dt_ctrl_t'(dead_time_ctrl_q))
            pdto_pkg::PDTO_DT_NEG: begin
                delay_fall = (output_pair_mode == pdto_pkg::PDTO_PM_COMPL);
                if (!delay_fall) begin
                    delay_h = 14'h0000;
                    delay_l = 14'h0000;
                end
            end
            pdto_pkg::PDTO_DT_OFF: begin
                delay_h = 14'h0000;
                delay_l = 14'h0000;
            end
            default: delay_fall = 1'b0;
        endcase
    end

    pdto_deadband u_db_high (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .sig_in        (pair_h),
        .delay_in      (delay_h),
        .delay_fall_in (delay_fall),
        .sig_out       (db_h)
    );

    pdto_deadband u_db_low (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .sig_in        (pair_l),
        .delay_in      (delay_l),
        .delay_fall_in (delay_fall),
        .sig_out       (db_l)
    );

    // =====================================================
    // Override, protection, polarity
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ov_en_eff_q  <= 2'h0;
            ov_dat_eff_q <= 2'h0;
        end else if (!io_q[`PDTO_IO_OVERRIDE_TIME_SYNC] || period_end_in) begin
            ov_en_eff_q  <= {io_q[`PDTO_IO_OVEN_H], io_q[`PDTO_IO_OVEN_L]};
            ov_dat_eff_q <= {io_q[`PDTO_IO_OVD_H], io_q[`PDTO_IO_OVD_L]};
        end
    end

    assign sw_h = io_q[`PDTO_IO_SWAP] ? db_l : db_h;
    assign sw_l = io_q[`PDTO_IO_SWAP] ? db_h : db_l;

    always_comb begin
        lvl_h = ov_en_eff_q[1] ? ov_dat_eff_q[1] : sw_h;
        lvl_l = ov_en_eff_q[0] ? ov_dat_eff_q[0] : sw_l;
        if (fault_active_in) begin
            lvl_h = io_q[`PDTO_IO_FLT_H];
            lvl_l = io_q[`PDTO_IO_FLT_L];
        end else if (limit_active_in && current_limit_mode_in) begin
            lvl_h = io_q[`PDTO_IO_CL_H];
            lvl_l = io_q[`PDTO_IO_CL_L];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            high_q <= 1'b0;
            low_q  <= 1'b0;
        end else begin
            high_q <= lvl_h ^ io_q[`PDTO_IO_POL_H];
            low_q  <= lvl_l ^ io_q[`PDTO_IO_POL_L];
        end
    end

    assign high_output_out = high_q;
    assign low_output_out  = low_q;

    // =====================================================
    // Checks
    sequence s_fault_on;
        fault_active_in;
    endsequence

    sequence s_limit_only;
        !fault_active_in && limit_active_in && current_limit_mode_in;
    endsequence

    chk_dt_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (rvalid_q && rd_addr_q == `PDTO_ADDR_DT) |-> rdata_q[31:14] == 18'h00000)
        else $error("dead time upper bits not zero");
    chk_alt_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (wr_fire && wr_addr_q == `PDTO_ADDR_ALT && wr_strb_q == 2'h3)
        |=> alt_shadow_q == $past(wr_data_q[13:0]))
        else $error("alternate dead time not stored");
    chk_trig_divide: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        trig_q |-> $past(trig_event_in) && $past(div_cnt_q) >= $past(trigger_divider_q))
        else $error("trigger emitted off divider");
    chk_start_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (trg_state_q == pdto_pkg::PDTO_TRG_WAIT) |=> !trig_q)
        else $error("trigger during start delay");
    chk_secondary_irq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        trig_irq_req_out |-> PRIMARY_GEN && trig_out)
        else $error("trigger request from secondary");
    chk_fault_force: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        s_fault_on |=> high_q == ($past(io_q[`PDTO_IO_FLT_H]) ^ $past(io_q[`PDTO_IO_POL_H]))
                    && low_q == ($past(io_q[`PDTO_IO_FLT_L]) ^ $past(io_q[`PDTO_IO_POL_L])))
        else $error("fault data not forced");
    chk_limit_force: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        s_limit_only |=> high_q == ($past(io_q[`PDTO_IO_CL_H]) ^ $past(io_q[`PDTO_IO_POL_H])))
        else $error("limit data not forced");
    chk_lock_refuse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (wr_fire && wr_addr_q == `PDTO_ADDR_IO && !io_write_ok) |=> $stable(io_q))
        else $error("locked register written");
    chk_dt_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        (!immediate_update_q && !period_end_in) |=> $stable(dt_active_q))
        else $error("dead time moved off boundary");

endmodule : pdto_top
`default_nettype wire

/* File: include/pdto_map.svh */
// Register offsets, field positions, reset values and response codes
`ifndef PDTO_MAP_SVH
`define PDTO_MAP_SVH

// =====================================================
// Offsets
`define PDTO_ADDR_DT        8'h00
`define PDTO_ADDR_ALT       8'h04
`define PDTO_ADDR_TRG       8'h08
`define PDTO_ADDR_IO        8'h0c
`define PDTO_ADDR_CTRL      8'h10
`define PDTO_ADDR_STAT      8'h14

// =====================================================
// Fields
`define PDTO_DT_W           14
`define PDTO_TRG_DIV_LSB    12
`define PDTO_TRG_STRT_LSB   0
`define PDTO_IO_OWN_H       15
`define PDTO_IO_OWN_L       14
`define PDTO_IO_POL_H       13
`define PDTO_IO_POL_L       12
`define PDTO_IO_MODE_LSB    10
`define PDTO_IO_OVEN_H      9
`define PDTO_IO_OVEN_L      8
`define PDTO_IO_OVD_H       7
`define PDTO_IO_OVD_L       6
`define PDTO_IO_FLT_H       5
`define PDTO_IO_FLT_L       4
`define PDTO_IO_CL_H        3
`define PDTO_IO_CL_L        2
`define PDTO_IO_SWAP        1
`define PDTO_IO_OVERRIDE_TIME_SYNC       0
`define PDTO_CTRL_DTC_LSB   6
`define PDTO_CTRL_IUE       0

// =====================================================
// Reset values and responses
`define PDTO_RST_IO         16'hc000
`define PDTO_RESP_OKAY      2'h0
`define PDTO_RESP_SLVERR    2'h2

`endif

/* File: include/pdto_pkg.sv */
// Types shared by the output slice
package pdto_pkg;

    typedef enum logic [1:0] {
        PDTO_PM_COMPL = 2'h0,
        PDTO_PM_REDUN = 2'h1,
        PDTO_PM_PUSH  = 2'h2,
        PDTO_PM_RSVD  = 2'h3
    } pdto_pair_mode_t;

    typedef enum logic [1:0] {
        PDTO_DT_POS  = 2'h0,
        PDTO_DT_NEG  = 2'h1,
        PDTO_DT_OFF  = 2'h2,
        PDTO_DT_COMP = 2'h3
    } pdto_dt_ctrl_t;

    typedef enum logic [2:0] {
        PDTO_TRG_OFF  = 3'h1,
        PDTO_TRG_WAIT = 3'h2,
        PDTO_TRG_RUN  = 3'h4
    } pdto_trg_state_t;

endpackage : pdto_pkg

/* File: tb/pdto_power_stage.sv */
// Power switch pair model driven by the pin pair
`timescale 1ns/1ps
`default_nettype none
module pdto_power_stage (
    input  wire logic clk_in,
    input  wire logic high_pin_in,
    input  wire logic low_pin_in,
    input  wire logic high_own_in,
    input  wire logic low_own_in,
    output var logic  both_on_out
);
    // A switch only follows a pin that the slice owns
    always_ff @(posedge clk_in) begin
        both_on_out <= high_own_in & high_pin_in & low_own_in & low_pin_in;
    end
endmodule : pdto_power_stage
`default_nettype wire

/* File: tb/pwm_deadtime_trigger_output_ctrl_bench.sv */
// Bench for the dead-time, trigger and pin control slice
`timescale 1ns/1ps
`default_nettype none
module pwm_deadtime_trigger_output_ctrl_bench;
    logic clk_in, rst_b_in, awv, wv, bre, arv, rre, en, pe, ev, flt, lim, clm, lck, unl, gh;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd;
    logic [1:0] br, rr, r;
    logic awr, wrd, bv, arr, rv, ho, lo, hown, lown, trg, irq, sw_on;
    logic [31:0] v;
    logic [13:0] dto, adto;
    int n_errors, checked, cyc, ntrg, nirq, nboth;
    pdto_top i_dut (.clk_in, .rst_b_in, .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'h3),
        .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_araddr_in(ara),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre),
        .pwm_module_enable_in(en), .period_end_in(pe), .trig_event_in(ev),
        .gen_high_in(gh), .fault_active_in(flt), .limit_active_in(lim),
        .current_limit_mode_in(clm), .write_lock_config_in(lck), .unlock_seq_in(unl),
        .high_output_out(ho), .low_output_out(lo), .high_pin_owner_out(hown),
        .low_pin_owner_out(lown), .trig_out(trg), .trig_irq_req_out(irq),
        .dead_time_value_out(dto), .alt_dead_time_value_out(adto));
    pdto_power_stage i_stage (.clk_in, .high_pin_in(ho), .low_pin_in(lo),
        .high_own_in(hown), .low_own_in(lown), .both_on_out(sw_on));
    // ==================================
    // Clock, reset, timeout
    initial begin
        clk_in = 0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        ntrg += trg;
        nirq += irq;
        nboth += sw_on;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // ==================================
    // Bus tasks
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic aw_todo = 1'b1;
        logic w_todo = 1'b1;
        awa <= a;
        wd <= {16'h0, d};
        awv <= 1;
        wv <= 1;
        bre <= 1;
        while (aw_todo || w_todo) begin
            @(posedge clk_in);
            if (aw_todo && awr) begin
                aw_todo = 1'b0;
                awv <= 0;
            end
            if (w_todo && wrd) begin
                w_todo = 1'b0;
                wv <= 0;
            end
        end
        do @(posedge clk_in); while (!bv);
        r = br;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        ara <= a; arv <= 1; rre <= 1;
        do @(posedge clk_in); while (!arr);
        arv <= 0;
        do @(posedge clk_in); while (!rv);
        v = rd;
        rre <= 0;
    endtask : rdr
    task automatic pins(input logic h, input logic l);
        repeat (4) @(posedge clk_in);
        chk({ho, lo}, {h, l});
    endtask : pins
    // ==================================
    // Scenarios
    task automatic t_regs();
        rdr(8'h0c); chk(v, 32'hc000);
        chk({hown, lown}, 2'h3);
        for (int i = 0; i < 2; i++) begin
            wr(8'(4 * i), 16'hffff); chk(r, 2'h0);
            rdr(8'(4 * i)); chk(v, 32'h3fff);
        end
        wr(8'h18, 16'h1234); chk(r, 2'h2);
        $display("regs done");
    endtask : t_regs
    task automatic t_pins();
        lck <= 1;
        wr(8'h0c, 16'hd39c); chk(r, 2'h2);
        unl <= 1; @(posedge clk_in); unl <= 0;
        wr(8'h0c, 16'hd39c); chk(r, 2'h0);
        pins(1, 1);
        flt <= 1; lim <= 1; clm <= 1;
        pins(0, 0);
        flt <= 0;
        pins(1, 0);
        lim <= 0;
        $display("pins done");
    endtask : t_pins
    task automatic t_dead();
        lck <= 0;
        chk({4'h0, dto, adto}, 32'h0);
        wr(8'h00, 16'h0004);
        wr(8'h04, 16'h0002);
        pe <= 1;
        @(posedge clk_in);
        pe <= 0;
        @(posedge clk_in);
        chk({4'h0, dto, adto}, {4'h0, 14'h0004, 14'h0002});
        wr(8'h0c, 16'hc000); chk(r, 2'h0);
        pins(0, 1);
        nboth = 0;
        gh <= 1;
        pins(0, 0);
        pins(1, 0);
        gh <= 0;
        pins(0, 0);
        pins(0, 1);
        wr(8'h0c, 16'hc002);
        pins(1, 0);
        chk(nboth, 0);
        $display("dead done");
    endtask : t_dead
    task automatic pulse_events(input int n);
        repeat (n) begin
            ev <= 1;
            @(posedge clk_in);
            ev <= 0;
            repeat (3) @(posedge clk_in);
        end
    endtask : pulse_events
    task automatic t_trig();
        wr(8'h08, 16'h0002);
        en <= 1;
        repeat (3) @(posedge clk_in);
        ntrg = 0;
        nirq = 0;
        repeat (2) begin
            pulse_events(1);
            pe <= 1;
            @(posedge clk_in);
            pe <= 0;
        end
        chk(ntrg, 0);
        pulse_events(3);
        chk(ntrg, 3);
        wr(8'h08, 16'h2002);
        pulse_events(6);
        chk(ntrg, 5);
        chk(nirq, 5);
        $display("trig done");
    endtask : t_trig
    task automatic complete_run();
        $display("errors %0d checked %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial begin
        {rst_b_in, awv, wv, bre, arv, rre, en, pe, ev, flt, lim, clm, lck, unl, gh} = '0;
        {awa, ara, wd} = '0;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1;
        t_regs();
        t_pins();
        t_dead();
        t_trig();
        complete_run();
    end
endmodule : pwm_deadtime_trigger_output_ctrl_bench
`default_nettype wire
